// ### cocr_map.svh
`ifndef COCR_MAP_SVH
`define COCR_MAP_SVH

// ****************************************
// serial slave
// ****************************************
`define COCR_SLAVE_ADDR    8'hd2
`define COCR_BLOCK_COUNT   8'h07
`define COCR_BITS_PER_BYTE 4'h8
`define COCR_LAST_BIT      4'h7
`define COCR_CMD_SINGLE    7
`define COCR_CMD_CS        6:5
`define COCR_CMD_IDX       4:0

// ****************************************
// byte offsets
// ****************************************
`define COCR_OFS_LANE_EN   5'h00
`define COCR_OFS_SE_EN     5'h01
`define COCR_OFS_SPREAD    5'h02
`define COCR_OFS_MODES     5'h03
`define COCR_OFS_REQ0      5'h04
`define COCR_OFS_REQ1      5'h05
`define COCR_OFS_TEST      5'h06

// ****************************************
// power-up values
// ****************************************
`define COCR_RST_B0        8'hff
`define COCR_RST_B1        8'hff
`define COCR_RST_B2        8'heb
`define COCR_RST_B3        8'haf
`define COCR_RST_B4        8'h03
`define COCR_RST_B5        8'h00
`define COCR_RST_B6        8'h00
`define COCR_B6_WMASK      8'hf0
`define COCR_SYNC_RST      9'h1ff

// ****************************************
// field positions
// ****************************************
`define COCR_B0_LANE       7:2
`define COCR_B0_SPARE      1:0
`define COCR_B1_XTAL       7:5
`define COCR_B1_BUS33      4
`define COCR_B1_BUS48      3
`define COCR_B1_HOST       2:0
`define COCR_B2_DEEP       7
`define COCR_B2_DRV48      6
`define COCR_B2_DRV33      5
`define COCR_B2_SPREAD     2
`define COCR_B3_REQ_HIZ    7
`define COCR_B3_HOST_PD    6
`define COCR_B3_LANE_PD    5
`define COCR_B3_HALT_HIZ   4
`define COCR_B3_HALT_MASK  3:1
`define COCR_B45_MAP       7:2
`define COCR_B6_TSEL       7
`define COCR_B6_TMODE      6
`define COCR_B6_XDRV       5
`define COCR_B6_STRAP      3:0

`endif

// ### cocr_pkg.sv
package cocr_pkg;
    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_RX   = 5'h02,
        ST_ACK  = 5'h04,
        ST_TX   = 5'h08,
        ST_RACK = 5'h10
    } cocr_state_t;
    typedef enum logic [2:0] {
        SG_ADDR = 3'h1,
        SG_CMD  = 3'h2,
        SG_DATA = 3'h4
    } cocr_stage_t;
    typedef logic [7:0] cocr_byte_t;
endpackage

// ### cocr_pins_if.sv
interface cocr_pins_if;
    logic       scl;
    logic       sda;
    logic       pg_n;
    logic [1:0] req_n;
    logic [3:0] strap;
    logic       strap_ok;
    logic [3:0] strap_q;
    modport syncer (output scl, sda, pg_n, req_n, strap);
    modport latch  (input pg_n, strap, output strap_ok, strap_q);
    modport core   (input scl, sda, req_n, strap_ok, strap_q);
endinterface

// ### cocr_sync.sv
`include "cocr_map.svh"
module cocr_sync
(
    input  wire logic       sys_clk_i,
    input  wire logic       arst_n_i,
    input  wire logic [8:0] raw_i,
    cocr_pins_if.syncer     pins
);
    import cocr_pkg::*;
    logic [8:0] ff1;
    logic [8:0] ff2;
    logic [8:0] ff3;
    logic [8:0] filt;

    // a change only counts when the last two stages agree
    for (genvar b = 0; b < 9; b++)
    begin : g_bit
        always_ff @(posedge sys_clk_i or negedge arst_n_i)
        begin
            if (!arst_n_i)
            begin
                ff1[b]  <= 1'h1;
                ff2[b]  <= 1'h1;
                ff3[b]  <= 1'h1;
                filt[b] <= 1'h1;
            end
            else
            begin
                ff1[b] <= raw_i[b];
                ff2[b] <= ff1[b];
                ff3[b] <= ff2[b];
                if (ff2[b] == ff3[b])
                    filt[b] <= ff3[b];
            end
        end
    end

    assign pins.scl   = filt[0];
    assign pins.sda   = filt[1];
    assign pins.pg_n  = filt[2];
    assign pins.req_n = filt[4:3];
    assign pins.strap = filt[8:5];
endmodule // cocr_sync

// ### cocr_strap.sv
module cocr_strap
(
    input  wire logic   sys_clk_i,
    input  wire logic   arst_n_i,
    cocr_pins_if.latch  pins
);
    import cocr_pkg::*;
    logic       taken;
    logic [3:0] held;

    // one-shot: later supply-good or strap changes are ignored
    always_ff @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            taken <= 1'h0;
            held  <= 4'h0;
        end
        else if (!taken && !pins.pg_n)
        begin
            taken <= 1'h1;
            held  <= pins.strap;
        end
    end

    assign pins.strap_ok = taken;
    assign pins.strap_q  = held;

    AST_STRAP_ONESHOT: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        taken |=> taken && $stable(held))
        else $error("strap readback changed after latch");
endmodule // cocr_strap

// ### cocr_top.sv
// Contract
// - byte 0 drives lane and spare pair enables
// - byte 1 high bits enable single-ended clocks
// - byte 1 low bits enable host pairs
// - byte 2 bit 7 picks spread depth
// - byte 2 bits 6,5 set bus drive
// - byte 2 bit 2 enables spread, default off
// - byte 3 bit 7 request-stop tri-state mode
// - byte 3 bit 6 host power-down mode
// - byte 3 bit 5 lane power-down mode
// - byte 3 bit 4 host halt mode
// - byte 3 bits 3..1 host halt mask
// - byte 4 maps lanes to request 0
// - byte 5 maps lanes to request 1
// - byte 6 bits 7,6 test clock mode
// - byte 6 bit 5 crystal copy drive
// - byte 6 low bits read latched straps
// - all bytes load defaults at reset
// - answer only slave address 11010010
// - command bit 7 single, 6:5 zero, index
`include "cocr_map.svh"
module cocr_top
(
    input  wire logic       sys_clk_i,
    input  wire logic       arst_n_i,
    input  wire logic       smb_clk_i,
    input  wire logic       smb_data_i,
    output logic            smb_data_o,
    output logic            smb_data_oe_o,
    input  wire logic       supply_good_strobe_n_i,
    input  wire logic [1:0] lane_clock_request_n_i,
    input  wire logic       freq_sel_a_strap_i,
    input  wire logic       freq_sel_b_strap_i,
    input  wire logic       freq_sel_c_strap_i,
    input  wire logic       table_sel_strap_i,
    output logic [5:0]      lane_clock_en_o,
    output logic [1:0]      spare_lane_clock_en_o,
    output logic [2:0]      xtal_copy_en_o,
    output logic            bus33_clock_en_o,
    output logic            bus48_clock_en_o,
    output logic [2:0]      host_clock_en_o,
    output logic            spread_deep_o,
    output logic            bus48_strong_o,
    output logic            bus33_strong_o,
    output logic            spread_on_o,
    output logic            lane_req_stop_hiz_o,
    output logic            host_pd_hiz_o,
    output logic            lane_pd_hiz_o,
    output logic            host_halt_hiz_o,
    output logic [2:0]      host_halt_mask_o,
    output logic [5:0]      lane_stop_o,
    output logic            test_mode_o,
    output logic            test_divided_o,
    output logic            xtal_copy_strong_o,
    output logic            straps_valid_o,
    output logic [3:0]      straps_o
);
    import cocr_pkg::*;

    // ****************************************
    // pin conditioning and strap capture
    // ****************************************
    cocr_pins_if pins ();

    cocr_sync u_sync (
        .sys_clk_i (sys_clk_i),
        .arst_n_i  (arst_n_i),
        .raw_i     ({table_sel_strap_i, freq_sel_c_strap_i, freq_sel_b_strap_i,
                     freq_sel_a_strap_i, lane_clock_request_n_i,
                     supply_good_strobe_n_i, smb_data_i, smb_clk_i}),
        .pins      (pins)
    );

    cocr_strap u_strap (
        .sys_clk_i (sys_clk_i),
        .arst_n_i  (arst_n_i),
        .pins      (pins)
    );

    // ****************************************
    // serial bus edges
    // ****************************************
    localparam cocr_byte_t SLV_ADDR = `COCR_SLAVE_ADDR;

    logic scl_q;
    logic sda_q;
    logic scl_rise;
    logic scl_fall;
    logic start_c;
    logic stop_c;

    always_ff @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            scl_q <= 1'h1;
            sda_q <= 1'h1;
        end
        else
        begin
            scl_q <= pins.scl;
            sda_q <= pins.sda;
        end
    end

    assign scl_rise = pins.scl && !scl_q;
    assign scl_fall = !pins.scl && scl_q;
    // data moving while the clock is high frames a transfer
    assign start_c  = pins.scl && scl_q && sda_q && !pins.sda;
    assign stop_c   = pins.scl && scl_q && !sda_q && pins.sda;

    // ****************************************
    // byte engine
    // ****************************************
    cocr_state_t state;
    cocr_stage_t stage;
    logic [3:0]  bitcnt;
    cocr_byte_t  shreg;
    cocr_byte_t  rdata;
    logic        rd;
    logic        blk;
    logic        cnt_ph;
    logic        drive;
    logic [4:0]  idx;
    logic        byte_done;
    logic        addr_hit;
    logic        cmd_ok;
    logic        wr_en;
    cocr_byte_t  ctl [7];

    assign byte_done = (state == ST_RX) && scl_fall && (bitcnt == `COCR_BITS_PER_BYTE);
    assign addr_hit  = shreg[7:1] == SLV_ADDR[7:1];
    assign cmd_ok    = shreg[`COCR_CMD_CS] == 2'h0;
    // block transfers open with a byte count that is not stored
    assign wr_en     = byte_done && (stage == SG_DATA) && !(blk && cnt_ph)
                       && (idx <= `COCR_OFS_TEST);

    // the identification byte is not held here, so it reads as zero
    always_comb
    begin
        rdata = 8'h00;
        if (blk && cnt_ph)
            rdata = `COCR_BLOCK_COUNT;
        else if (idx == `COCR_OFS_TEST)
            rdata = {ctl[6][7:4], pins.strap_q};
        else if (idx < `COCR_OFS_TEST)
            rdata = ctl[idx[2:0]];
    end

    always_ff @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            state  <= ST_IDLE;
            stage  <= SG_ADDR;
            bitcnt <= 4'h0;
            shreg  <= 8'h00;
            rd     <= 1'h0;
            blk    <= 1'h0;
            cnt_ph <= 1'h0;
            drive  <= 1'h0;
            idx    <= 5'h00;
        end
        else if (start_c)
        begin
            state  <= ST_RX;
            stage  <= SG_ADDR;
            bitcnt <= 4'h0;
            drive  <= 1'h0;
        end
        else if (stop_c)
        begin
            state <= ST_IDLE;
            drive <= 1'h0;
        end
        else
        begin
            case (state)
                ST_RX:
                begin
                    if (scl_rise)
                    begin
                        shreg  <= {shreg[6:0], pins.sda};
                        bitcnt <= bitcnt + 4'h1;
                    end
                    else if (byte_done)
                    begin
                        case (stage)
                            SG_ADDR:
                            begin
                                rd    <= shreg[0];
                                state <= addr_hit ? ST_ACK : ST_IDLE;
                                drive <= addr_hit;
                            end
                            SG_CMD:
                            begin
                                blk    <= !shreg[`COCR_CMD_SINGLE];
                                cnt_ph <= !shreg[`COCR_CMD_SINGLE];
                                idx    <= shreg[`COCR_CMD_IDX];
                                state  <= cmd_ok ? ST_ACK : ST_IDLE;
                                drive  <= cmd_ok;
                            end
                            default:
                            begin
                                if (blk && cnt_ph)
                                    cnt_ph <= 1'h0;
                                else if (blk)
                                    idx <= idx + 5'h01;
                                state <= ST_ACK;
                                drive <= 1'h1;
                            end
                        endcase
                    end
                end
                ST_ACK:
                begin
                    if (scl_fall)
                    begin
                        bitcnt <= 4'h0;
                        if (rd)
                        begin
                            state <= ST_TX;
                            shreg <= rdata;
                            drive <= !rdata[7];
                            if (blk && cnt_ph)
                                cnt_ph <= 1'h0;
                            else if (blk)
                                idx <= idx + 5'h01;
                        end
                        else
                        begin
                            state <= ST_RX;
                            drive <= 1'h0;
                            stage <= (stage == SG_ADDR) ? SG_CMD : SG_DATA;
                        end
                    end
                end
                ST_TX:
                begin
                    if (scl_fall)
                    begin
                        if (bitcnt == `COCR_LAST_BIT)
                        begin
                            state <= ST_RACK;
                            drive <= 1'h0;
                        end
                        else
                        begin
                            shreg  <= {shreg[6:0], 1'h0};
                            drive  <= !shreg[6];
                            bitcnt <= bitcnt + 4'h1;
                        end
                    end
                end
                ST_RACK:
                begin
                    // a not-acknowledge from the host ends the read
                    if (scl_rise && pins.sda)
                        state <= ST_IDLE;
                    else if (scl_fall)
                    begin
                        state  <= ST_TX;
                        bitcnt <= 4'h0;
                        shreg  <= rdata;
                        drive  <= !rdata[7];
                        if (blk && cnt_ph)
                            cnt_ph <= 1'h0;
                        else if (blk)
                            idx <= idx + 5'h01;
                    end
                end
                default:
                begin
                    state <= ST_IDLE;
                    drive <= 1'h0;
                end
            endcase
        end
    end

    // open drain: only ever pulls low
    assign smb_data_o    = 1'h0;
    assign smb_data_oe_o = drive;

    // ****************************************
    // control bytes
    // ****************************************
    always_ff @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            ctl[0] <= `COCR_RST_B0;
            ctl[1] <= `COCR_RST_B1;
            ctl[2] <= `COCR_RST_B2;
            ctl[3] <= `COCR_RST_B3;
            ctl[4] <= `COCR_RST_B4;
            ctl[5] <= `COCR_RST_B5;
            ctl[6] <= `COCR_RST_B6;
        end
        else if (wr_en)
        begin
            // reserved bits simply store, strap bits keep their zero
            if (idx == `COCR_OFS_TEST)
                ctl[6] <= shreg & `COCR_B6_WMASK;
            else
                ctl[idx[2:0]] <= shreg;
        end
    end

    // request input high means the clock is not wanted
    for (genvar l = 0; l < 6; l++)
    begin : g_lane
        always_ff @(posedge sys_clk_i or negedge arst_n_i)
        begin
            if (!arst_n_i)
                lane_stop_o[l] <= 1'h0;
            else
                lane_stop_o[l] <= (ctl[4][l + 2] && pins.req_n[0])
                                  || (ctl[5][l + 2] && pins.req_n[1]);
        end
    end

    assign lane_clock_en_o       = ctl[0][`COCR_B0_LANE];
    assign spare_lane_clock_en_o = ctl[0][`COCR_B0_SPARE];
    assign xtal_copy_en_o        = ctl[1][`COCR_B1_XTAL];
    assign bus33_clock_en_o      = ctl[1][`COCR_B1_BUS33];
    assign bus48_clock_en_o      = ctl[1][`COCR_B1_BUS48];
    assign host_clock_en_o       = ctl[1][`COCR_B1_HOST];
    assign spread_deep_o         = ctl[2][`COCR_B2_DEEP];
    assign bus48_strong_o        = ctl[2][`COCR_B2_DRV48];
    assign bus33_strong_o        = ctl[2][`COCR_B2_DRV33];
    assign spread_on_o           = ctl[2][`COCR_B2_SPREAD];
    assign lane_req_stop_hiz_o   = ctl[3][`COCR_B3_REQ_HIZ];
    assign host_pd_hiz_o         = ctl[3][`COCR_B3_HOST_PD];
    assign lane_pd_hiz_o         = ctl[3][`COCR_B3_LANE_PD];
    assign host_halt_hiz_o       = ctl[3][`COCR_B3_HALT_HIZ];
    assign host_halt_mask_o      = ctl[3][`COCR_B3_HALT_MASK];
    assign test_mode_o           = ctl[6][`COCR_B6_TMODE];
    assign test_divided_o        = ctl[6][`COCR_B6_TSEL];
    assign xtal_copy_strong_o    = ctl[6][`COCR_B6_XDRV];
    assign straps_valid_o        = pins.strap_ok;
    assign straps_o              = pins.strap_q;

    // ****************************************
    // checks
    // ****************************************
    AST_LANE_WRITE: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        wr_en && idx == `COCR_OFS_LANE_EN |=> {lane_clock_en_o, spare_lane_clock_en_o} == $past(shreg))
        else $error("lane enables did not follow byte 0 write");
    AST_SE_WRITE: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        wr_en && idx == `COCR_OFS_SE_EN |=> {xtal_copy_en_o, bus33_clock_en_o, bus48_clock_en_o}
            == $past(shreg[7:3]))
        else $error("single-ended enables did not follow byte 1 write");
    AST_HOST_WRITE: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        wr_en && idx == `COCR_OFS_SE_EN |=> host_clock_en_o == $past(shreg[2:0]))
        else $error("host enables did not follow byte 1 write");
    AST_SPREAD_WRITE: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        wr_en && idx == `COCR_OFS_SPREAD |=> spread_deep_o == $past(shreg[7])
            && spread_on_o == $past(shreg[2]))
        else $error("spread controls did not follow byte 2 write");
    AST_TEST_WRITE: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        wr_en && idx == `COCR_OFS_TEST |=> test_mode_o == $past(shreg[6])
            && test_divided_o == $past(shreg[7]) && $stable(straps_o))
        else $error("test controls wrong or straps disturbed");
    AST_LANE_STOP: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        ##1 lane_stop_o == $past((ctl[4][7:2] & {6{pins.req_n[0]}}) | (ctl[5][7:2] & {6{pins.req_n[1]}})))
        else $error("lane stop does not follow request mapping");
    AST_ADDR_MISS: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        byte_done && stage == SG_ADDR && !addr_hit && !start_c && !stop_c
            |=> state == ST_IDLE && !smb_data_oe_o)
        else $error("foreign address was acknowledged");
    AST_CMD_CS: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        byte_done && stage == SG_CMD && !cmd_ok && !start_c && !stop_c
            |=> state == ST_IDLE && !smb_data_oe_o)
        else $error("command with nonzero select was acknowledged");
    AST_STRAP_READ: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        idx == `COCR_OFS_TEST && !(blk && cnt_ph) |-> rdata[3:0] == pins.strap_q)
        else $error("strap readback does not show latched straps");
endmodule // cocr_top

// ### cocr_host.sv
`include "cocr_map.svh"
module cocr_host
(
    output logic      scl_o,
    output logic      sda_o,
    input  wire logic sda_i
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************
    // bus phases
    // ****************************************
    // half phases well above the pin filter so no edge is lost
    localparam int PH = 160;
    initial
    begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end
    task automatic start();
        #PH sda_o = 1'b1;
        #PH scl_o = 1'b1;
        #PH sda_o = 1'b0;
        #PH scl_o = 1'b0;
    endtask
    task automatic stop();
        #PH sda_o = 1'b0;
        #PH scl_o = 1'b1;
        #PH sda_o = 1'b1;
        #PH;
    endtask
    // eight bits then the answer bit, which the host always releases
    task automatic xbyte(input logic [7:0] d, output logic [7:0] q, output logic ack);
        logic [8:0] s;
        logic [8:0] o;
        o = {d, 1'b1};
        for (int i = 8; i >= 0; i--)
        begin
            #(PH/2) sda_o = o[i];
            #(PH/2) scl_o = 1'b1;
            #(PH/2) s[i] = sda_i;
            #(PH/2) scl_o = 1'b0;
        end
        q = s[8:1];
        ack = ~s[0];
    endtask
    task automatic wr(input logic [7:0] adr, input logic [7:0] cmd, input logic [7:0] d, output logic ok);
        logic [7:0] q;
        logic       a1;
        logic       a2;
        logic       a3;
        start();
        xbyte(adr, q, a1);
        xbyte(cmd, q, a2);
        xbyte(d, q, a3);
        stop();
        ok = a1 & a2 & a3;
    endtask
    // read ends with a released answer bit, i.e. a not-acknowledge
    task automatic rd(input logic [7:0] cmd, output logic [7:0] q);
        logic a;
        start();
        xbyte(`COCR_SLAVE_ADDR, q, a);
        xbyte(cmd, q, a);
        start();
        xbyte(`COCR_SLAVE_ADDR | 8'h01, q, a);
        xbyte(8'hff, q, a);
        stop();
    endtask
endmodule // cocr_host

// ### testbench.sv
`include "cocr_map.svh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk_i = 0, arst_n_i = 0, smb_clk_i, sda_h, smb_data_o, smb_data_oe_o;
    logic supply_good_strobe_n_i = 1, freq_sel_a_strap_i, freq_sel_b_strap_i, freq_sel_c_strap_i;
    logic table_sel_strap_i, bus33_clock_en_o, bus48_clock_en_o, spread_deep_o, bus48_strong_o;
    logic bus33_strong_o, spread_on_o, lane_req_stop_hiz_o, host_pd_hiz_o, lane_pd_hiz_o;
    logic host_halt_hiz_o, test_mode_o, test_divided_o, xtal_copy_strong_o, straps_valid_o, ok;
    logic [1:0] lane_clock_request_n_i = 2'b11, spare_lane_clock_en_o;
    logic [2:0] xtal_copy_en_o, host_clock_en_o, host_halt_mask_o;
    logic [5:0] lane_clock_en_o, lane_stop_o;
    logic [3:0] straps_o, strap = 4'ha;
    logic [7:0] q, e;
    logic [7:0] rst[7] = '{`COCR_RST_B0, `COCR_RST_B1, `COCR_RST_B2, `COCR_RST_B3, `COCR_RST_B4,
                           `COCR_RST_B5, `COCR_RST_B6};
    logic [7:0] m[7] = '{8'hff, 8'hff, 8'he4, 8'hfe, 8'h00, 8'h00, 8'he0};
    logic [7:0] r_i[7] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h06, 8'h06, 8'h04};
    logic [7:0] r_d[7] = '{8'h5a, 8'ha5, 8'h14, 8'h50, 8'hff, 8'h40, 8'h54};
    int fail_count = 0, n_compared = 0;
    // open-drain data line with pull-up
    wire smb_data_i = smb_data_oe_o ? (sda_h & smb_data_o) : sda_h;
    assign {table_sel_strap_i, freq_sel_c_strap_i, freq_sel_b_strap_i, freq_sel_a_strap_i} = strap;
    always #4 sys_clk_i = ~sys_clk_i;
    cocr_host cocr_host_inst (.scl_o(smb_clk_i), .sda_o(sda_h), .sda_i(smb_data_i));
    cocr_top cocr_top_inst (.sys_clk_i, .arst_n_i, .smb_clk_i, .smb_data_i, .smb_data_o, .smb_data_oe_o,
        .supply_good_strobe_n_i, .lane_clock_request_n_i, .freq_sel_a_strap_i, .freq_sel_b_strap_i,
        .freq_sel_c_strap_i, .table_sel_strap_i, .lane_clock_en_o, .spare_lane_clock_en_o,
        .xtal_copy_en_o, .bus33_clock_en_o, .bus48_clock_en_o, .host_clock_en_o, .spread_deep_o,
        .bus48_strong_o, .bus33_strong_o, .spread_on_o, .lane_req_stop_hiz_o, .host_pd_hiz_o,
        .lane_pd_hiz_o, .host_halt_hiz_o, .host_halt_mask_o, .lane_stop_o, .test_mode_o,
        .test_divided_o, .xtal_copy_strong_o, .straps_valid_o, .straps_o);
    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [7:0] obs(input int i);
        case (i)
            0: return {lane_clock_en_o, spare_lane_clock_en_o};
            1: return {xtal_copy_en_o, bus33_clock_en_o, bus48_clock_en_o, host_clock_en_o};
            2: return {spread_deep_o, bus48_strong_o, bus33_strong_o, 2'b00, spread_on_o, 2'b00};
            3: return {lane_req_stop_hiz_o, host_pd_hiz_o, lane_pd_hiz_o, host_halt_hiz_o,
                       host_halt_mask_o, 1'b0};
            6: return {test_divided_o, test_mode_o, xtal_copy_strong_o, 5'h00};
            default: return 8'h00;
        endcase
    endfunction
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp)
        begin
            $display("unexpected %s: expected %h seen %h", what, exp, got);
            fail_count++;
        end
    endtask
    task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp);
        cocr_host_inst.rd({3'b100, idx[4:0]}, q);
        check("readback", exp, q);
    endtask
    task automatic defaults();
        check("straps", {4'h1, strap}, {3'h0, straps_valid_o, straps_o});
        for (int i = 0; i < 7; i++)
        begin
            e = (i == 6) ? {rst[i][7:4], strap} : rst[i];
            rdchk(i[7:0], e);
            check("outputs", rst[i] & m[i], obs(i) & m[i]);
        end
    endtask
    task automatic complete_run();
        if (fail_count == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // ****************************************
    // sequence
    // ****************************************
    // a hang in the bus exchange ends the run here
    initial
    begin
        #800_000;
        fail_count++;
        complete_run();
    end
    initial
    begin
        repeat (5) @(negedge sys_clk_i);
        arst_n_i = 1;
        supply_good_strobe_n_i = 0;
        repeat (10) @(negedge sys_clk_i);
        defaults();
        for (int i = 0; i < 7; i++)
        begin
            cocr_host_inst.wr(`COCR_SLAVE_ADDR, {3'b100, r_i[i][4:0]}, r_d[i], ok);
            check("ack", 8'h01, {7'h0, ok});
            e = (r_i[i] == 8'h06) ? {r_d[i][7:4], strap} : r_d[i];
            rdchk(r_i[i], e);
            check("outputs", r_d[i] & m[r_i[i]], obs(r_i[i]) & m[r_i[i]]);
        end
        cocr_host_inst.wr(`COCR_SLAVE_ADDR, 8'h85, 8'ha8, ok);
        for (int k = 0; k < 4; k++)
        begin
            @(negedge sys_clk_i);
            lane_clock_request_n_i = k[1:0];
            repeat (10) @(negedge sys_clk_i);
            e = {({6{k[0]}} & 6'h15) | ({6{k[1]}} & 6'h2a), 2'b00};
            check("lane_stop", e, {lane_stop_o, 2'b00});
        end
        cocr_host_inst.wr(8'hd4, 8'h80, 8'h00, ok);
        check("ack", 8'h00, {7'h0, ok});
        cocr_host_inst.wr(`COCR_SLAVE_ADDR, 8'ha0, 8'h00, ok);
        check("ack", 8'h00, {7'h0, ok});
        rdchk(8'h00, 8'h5a);
        rdchk(8'h07, 8'h00);
        // block write: count byte first, then bytes from index 0 upward
        cocr_host_inst.start();
        cocr_host_inst.xbyte(`COCR_SLAVE_ADDR, q, ok);
        cocr_host_inst.xbyte(8'h00, q, ok);
        cocr_host_inst.xbyte(8'h02, q, ok);
        cocr_host_inst.xbyte(8'h3c, q, ok);
        cocr_host_inst.xbyte(8'hc3, q, ok);
        cocr_host_inst.stop();
        check("ack", 8'h01, {7'h0, ok});
        rdchk(8'h00, 8'h3c);
        rdchk(8'h01, 8'hc3);
        check("outputs", 8'h3c, obs(0));
        // block read opens with the byte count
        cocr_host_inst.start();
        cocr_host_inst.xbyte(`COCR_SLAVE_ADDR, q, ok);
        cocr_host_inst.xbyte(8'h00, q, ok);
        cocr_host_inst.start();
        cocr_host_inst.xbyte(`COCR_SLAVE_ADDR | 8'h01, q, ok);
        cocr_host_inst.xbyte(8'hff, q, ok);
        cocr_host_inst.stop();
        check("block_count", `COCR_BLOCK_COUNT, q);
        @(negedge sys_clk_i);
        arst_n_i = 0;
        strap = 4'h5;
        repeat (5) @(negedge sys_clk_i);
        arst_n_i = 1;
        repeat (10) @(negedge sys_clk_i);
        defaults();
        complete_run();
    end
endmodule // testbench
